// ### verilog/cpu_register_set_and_flags.sv
module cpu_register_set_and_flags
    import cpu_regs_pkg::*;
(
    input  wire logic      core_clk_i,
    input  wire logic      reset_n_i,
    input  wire reg_cmd_t  cmd_i,
    input  wire logic      irq_pending_i,
    output reg_view_t      view_o,
    output logic [15:0]    alu_operand_o,
    output logic [15:0]    index_addr_o,
    output logic [15:0]    stack_addr_o,
    output logic           irq_accept_o,
    output logic           signed_gt_o,
    output logic           signed_ge_o,
    output logic           signed_le_o,
    output logic           signed_lt_o
);
    logic [7:0]  acc_reg;
    logic [7:0]  acc_next;
    logic        acc_we;
    logic [7:0]  h_reg;
    logic [7:0]  x_reg;
    logic [7:0]  x_next;
    logic        x_we;
    logic [7:0]  h_next;
    logic        h_we;
    logic [15:0] sp_reg;
    logic [15:0] sp_next;
    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic        mask_cleared_reg;
    logic        mask_cleared_next;

    logic [7:0]  alu_b;
    logic        alu_sub;
    logic        alu_cin;
    logic [7:0]  alu_sum;
    logic        alu_c;
    logic        alu_h;
    logic        alu_v;

    logic [7:0]  bcd_corr;
    logic [8:0]  bcd_sum;
    logic        bcd_c;
    logic [7:0]  xres;
    logic        xc;
    logic [7:0]  logic_res;

    // ALU operand A is always the accumulator
    assign alu_operand_o = {8'h00, acc_reg};
    assign index_addr_o  = {h_reg, x_reg};
    assign stack_addr_o  = sp_reg;

    always_comb begin
        alu_b   = cmd_i.data8;
        alu_sub = (cmd_i.op == op_sub) || (cmd_i.op == op_sbc);
        alu_cin = 1'b0;
        if (cmd_i.op == op_adc || cmd_i.op == op_sbc) begin
            alu_cin = flags_reg[flag_c_pos];
        end
    end

    cpu_alu8 u_alu (
        .a_i     (acc_reg),
        .b_i     (alu_b),
        .carry_i (alu_cin),
        .sub_i   (alu_sub),
        .sum_o   (alu_sum),
        .carry_o (alu_c),
        .half_o  (alu_h),
        .ovf_o   (alu_v)
    );

    // decimal adjust correction
    always_comb begin
        bcd_corr = 8'h00;
        bcd_c    = flags_reg[flag_c_pos];
        if (flags_reg[flag_h_pos] || acc_reg[3:0] > 4'h9) begin
            bcd_corr[3:0] = 4'h6;
        end
        if (flags_reg[flag_c_pos] || acc_reg > 8'h99) begin
            bcd_corr[7:4] = 4'h6;
            bcd_c         = 1'b1;
        end
        bcd_sum = {1'b0, acc_reg} + {1'b0, bcd_corr};
    end

    // unary operations on index low byte
    always_comb begin
        xres = x_reg;
        xc   = flags_reg[flag_c_pos];
        unique case (cmd_i.op)
            op_xclr: xres = 8'h00;
            op_xinc: xres = x_reg + 8'h01;
            op_xdec: xres = x_reg - 8'h01;
            op_xcom: begin
                xres = ~x_reg;
                xc   = 1'b1;
            end
            op_xneg: begin
                xres = 8'h00 - x_reg;
                xc   = (x_reg != 8'h00);
            end
            op_xlsl: begin
                xres = {x_reg[6:0], 1'b0};
                xc   = x_reg[7];
            end
            op_xlsr: begin
                xres = {1'b0, x_reg[7:1]};
                xc   = x_reg[0];
            end
            op_xrol: begin
                xres = {x_reg[6:0], flags_reg[flag_c_pos]};
                xc   = x_reg[7];
            end
            op_xror: begin
                xres = {flags_reg[flag_c_pos], x_reg[7:1]};
                xc   = x_reg[0];
            end
            default: begin
                xres = x_reg;
                xc   = flags_reg[flag_c_pos];
            end
        endcase
    end

    always_comb begin
        logic_res = acc_reg & cmd_i.data8;
        if (cmd_i.op == op_or) begin
            logic_res = acc_reg | cmd_i.data8;
        end else if (cmd_i.op == op_eor) begin
            logic_res = acc_reg ^ cmd_i.data8;
        end
    end

    // data register and flag updates
    always_comb begin
        acc_next   = acc_reg;
        acc_we     = 1'b0;
        x_next     = x_reg;
        x_we       = 1'b0;
        h_next     = h_reg;
        h_we       = 1'b0;
        flags_next = flags_reg;
        mask_cleared_next = 1'b0;
        unique case (cmd_i.op)
            op_add, op_adc, op_sub, op_sbc: begin
                acc_next = alu_sum;
                acc_we   = 1'b1;
                flags_next[flag_v_pos] = alu_v;
                if (!alu_sub) begin
                    flags_next[flag_h_pos] = alu_h;
                end
                flags_next[flag_n_pos] = alu_sum[7];
                flags_next[flag_z_pos] = (alu_sum == 8'h00);
                flags_next[flag_c_pos] = alu_c;
            end
            op_and, op_or, op_eor: begin
                acc_next = logic_res;
                acc_we   = 1'b1;
                flags_next[flag_v_pos] = 1'b0;
                flags_next[flag_n_pos] = logic_res[7];
                flags_next[flag_z_pos] = (logic_res == 8'h00);
            end
            op_lda, op_sta: begin
                if (cmd_i.op == op_lda) begin
                    acc_next = cmd_i.data8;
                    acc_we   = 1'b1;
                end
                flags_next[flag_v_pos] = 1'b0;
                flags_next[flag_n_pos] = acc_next[7];
                flags_next[flag_z_pos] = (acc_next == 8'h00);
            end
            op_ldx, op_stx: begin
                if (cmd_i.op == op_ldx) begin
                    x_next = cmd_i.data8;
                    x_we   = 1'b1;
                end
                flags_next[flag_v_pos] = 1'b0;
                flags_next[flag_n_pos] = x_next[7];
                flags_next[flag_z_pos] = (x_next == 8'h00);
            end
            op_ldhx, op_sthx: begin
                if (cmd_i.op == op_ldhx) begin
                    {h_next, x_next} = cmd_i.data16;
                    h_we = 1'b1;
                    x_we = 1'b1;
                end
                flags_next[flag_v_pos] = 1'b0;
                flags_next[flag_n_pos] = h_next[7];
                flags_next[flag_z_pos] = ({h_next, x_next} == 16'h0000);
            end
            op_aix: begin
                {h_next, x_next} = {h_reg, x_reg}
                                 + {{8{cmd_i.data8[7]}}, cmd_i.data8};
                h_we = 1'b1;
                x_we = 1'b1;
            end
            op_decimal_adjust_instruction: begin
                acc_next = bcd_sum[7:0];
                acc_we   = 1'b1;
                flags_next[flag_n_pos] = bcd_sum[7];
                flags_next[flag_z_pos] = (bcd_sum[7:0] == 8'h00);
                flags_next[flag_c_pos] = bcd_c;
            end
            op_xclr, op_xinc, op_xdec, op_xcom, op_xneg,
            op_xlsl, op_xlsr, op_xrol, op_xror: begin
                x_next = xres;
                x_we   = 1'b1;
                flags_next[flag_n_pos] = xres[7];
                flags_next[flag_z_pos] = (xres == 8'h00);
                flags_next[flag_c_pos] = xc;
                flags_next[flag_v_pos] = xres[7] ^ xc;
                if (cmd_i.op == op_xinc) begin
                    flags_next[flag_v_pos] = (xres == 8'h80);
                    flags_next[flag_c_pos] = flags_reg[flag_c_pos];
                end else if (cmd_i.op == op_xdec) begin
                    flags_next[flag_v_pos] = (xres == 8'h7f);
                    flags_next[flag_c_pos] = flags_reg[flag_c_pos];
                end else if (cmd_i.op == op_xclr) begin
                    flags_next[flag_v_pos] = 1'b0;
                end else if (cmd_i.op == op_xcom) begin
                    flags_next[flag_v_pos] = 1'b0;
                end else if (cmd_i.op == op_xneg) begin
                    flags_next[flag_v_pos] = (xres == 8'h80);
                end
            end
            op_clear_mask_instruction: begin
                flags_next[flag_i_pos] = 1'b0;
                mask_cleared_next      = flags_reg[flag_i_pos];
            end
            op_sei: begin
                flags_next[flag_i_pos] = 1'b1;
            end
            op_tap: begin
                flags_next = cmd_i.data8 | flag_fixed_mask;
                mask_cleared_next = flags_reg[flag_i_pos]
                                  & ~cmd_i.data8[flag_i_pos];
            end
            op_tpa: begin
                acc_next = flags_reg;
                acc_we   = 1'b1;
            end
            default: begin
                acc_we = 1'b0;
            end
        endcase
        if (cmd_i.irq_stacked) begin
            flags_next[flag_i_pos] = 1'b1;
        end
        flags_next = flags_next | flag_fixed_mask;
    end

    // stack pointer update
    always_comb begin
        sp_next = sp_reg;
        if (cmd_i.op == op_add_immediate_to_stack) begin
            sp_next = sp_reg + {{8{cmd_i.data8[7]}}, cmd_i.data8};
        end else if (cmd_i.op == op_stack_pointer_low_reset) begin
            sp_next = {sp_reg[15:8], sp_low_reset};
        end else if (cmd_i.op == op_txs) begin
            sp_next = cmd_i.data16;
        end
    end

    // program counter update
    always_comb begin
        pc_next = pc_reg;
        unique case (cmd_i.pc_op)
            pc_hold:   pc_next = pc_reg;
            pc_inc:    pc_next = pc_reg + 16'h0001;
            pc_load:   pc_next = cmd_i.pc_data;
            pc_rel:    pc_next = pc_reg + cmd_i.pc_data;
            pc_vec_hi: pc_next = {cmd_i.pc_data[7:0], pc_reg[7:0]};
            pc_vec_lo: pc_next = {pc_reg[15:8], cmd_i.pc_data[7:0]};
            default:   pc_next = pc_reg;
        endcase
    end

    // accumulator keeps contents through reset
    always_ff @(posedge core_clk_i) begin
        if (acc_we) begin
            acc_reg <= acc_next;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (x_we) begin
            x_reg <= x_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            h_reg <= h_reset_value;
        end else if (h_we) begin
            h_reg <= h_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sp_reg <= sp_reset_value;
        end else begin
            sp_reg <= sp_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_reg <= pc_reset_value;
        end else begin
            pc_reg <= pc_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_reg <= flag_reset;
        end else begin
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_cleared_reg <= 1'b0;
        end else if (cmd_i.boundary || cmd_i.op != op_none) begin
            mask_cleared_reg <= mask_cleared_next;
        end
    end

    // interrupt gating at instruction boundary
    assign irq_accept_o = irq_pending_i && cmd_i.boundary
                        && !flags_reg[flag_i_pos]
                        && !mask_cleared_reg;

    // signed branch conditions
    always_comb begin
        signed_lt_o = flags_reg[flag_n_pos] ^ flags_reg[flag_v_pos];
        signed_ge_o = ~signed_lt_o;
        signed_le_o = signed_lt_o | flags_reg[flag_z_pos];
        signed_gt_o = ~signed_le_o;
    end

    assign view_o.accumulator        = acc_reg;
    assign view_o.index_pointer_pair = {h_reg, x_reg};
    assign view_o.stack_pointer      = sp_reg;
    assign view_o.program_counter    = pc_reg;
    assign view_o.condition_flags    = flags_reg | flag_fixed_mask;
endmodule

// ### verilog/cpu_regs_pkg.sv
// Overview of operation
// - 8-bit accumulator feeds ALU operand; reset leaves it unchanged.
// - reset forces index high byte to zero, low byte kept.
// - index pair is high:low address bytes; full 16 bits form pointer.
// - index low byte works as 8-bit data register for unary operations.
// - 16-bit stack pointer addresses next free stack location.
// - stack pointer loads 0x00ff on reset.
// - add-immediate-to-stack adds sign-extended 8-bit value to stack pointer.
// - stack-pointer-low reset changes only the low byte.
// - program counter increments per fetch; change-of-flow loads new address.
// - after reset program counter loads vector from 0xfffe (high), 0xffff (low).
// - condition flag bits 6 and 5 always read one.
// - bit 7 flags two's complement overflow; signed branches use it.
// - bit 4 records carry from bit 3 into bit 4 on adds.
// - decimal adjust uses half-carry and carry to correct BCD sum.
// - bit 3 masks maskable interrupts when set.
// - interrupt sets mask after stacking, before first handler instruction.
// - no interrupt accepted right after an instruction that clears the mask.
// - bit 2 set when result MSB is set (bit 7, or bit 15 for 16-bit results).
// - bit 1 set when result is zero, 8 or 16 bits.
// - loads and stores update negative and zero from moved value.
// - bit 0 is carry out or borrow; shifts, rotates, bit tests may set it.
package cpu_regs_pkg;
    localparam logic [15:0] sp_reset_value  = 16'h00ff;
    localparam logic [7:0]  h_reset_value   = 8'h00;
    localparam logic [15:0] pc_reset_value  = 16'h0000;
    localparam logic [7:0]  sp_low_reset    = 8'hff;
    localparam logic [15:0] vec_hi_addr     = 16'hfffe;
    localparam logic [15:0] vec_lo_addr     = 16'hffff;
    localparam int          flag_v_pos      = 7;
    localparam int          flag_one6_pos   = 6;
    localparam int          flag_one5_pos   = 5;
    localparam int          flag_h_pos      = 4;
    localparam int          flag_i_pos      = 3;
    localparam int          flag_n_pos      = 2;
    localparam int          flag_z_pos      = 1;
    localparam int          flag_c_pos      = 0;
    localparam logic [7:0]  flag_fixed_mask = 8'h60;
    localparam logic [7:0]  flag_reset      = 8'h68;

    typedef enum logic [4:0] {
        op_none  = 5'h00,
        op_add   = 5'h01,
        op_adc   = 5'h02,
        op_sub   = 5'h03,
        op_sbc   = 5'h04,
        op_and   = 5'h05,
        op_or    = 5'h06,
        op_eor   = 5'h07,
        op_lda   = 5'h08,
        op_ldx   = 5'h09,
        op_ldhx  = 5'h0a,
        op_sta   = 5'h0b,
        op_stx   = 5'h0c,
        op_sthx  = 5'h0d,
        op_decimal_adjust_instruction = 5'h0e,
        op_xclr  = 5'h0f,
        op_xinc  = 5'h10,
        op_xdec  = 5'h11,
        op_xcom  = 5'h12,
        op_xneg  = 5'h13,
        op_xlsl  = 5'h14,
        op_xlsr  = 5'h15,
        op_xrol  = 5'h16,
        op_xror  = 5'h17,
        op_add_immediate_to_stack = 5'h18,
        op_stack_pointer_low_reset = 5'h19,
        op_clear_mask_instruction = 5'h1a,
        op_sei   = 5'h1b,
        op_tap   = 5'h1c,
        op_tpa   = 5'h1d,
        op_txs   = 5'h1e,
        op_aix   = 5'h1f
    } reg_op_t;

    typedef enum logic [2:0] {
        pc_hold   = 3'h0,
        pc_inc    = 3'h1,
        pc_load   = 3'h2,
        pc_rel    = 3'h3,
        pc_vec_hi = 3'h4,
        pc_vec_lo = 3'h5
    } pc_op_t;

    typedef struct packed {
        reg_op_t     op;
        logic [7:0]  data8;
        logic [15:0] data16;
        pc_op_t      pc_op;
        logic [15:0] pc_data;
        logic        irq_stacked;
        logic        boundary;
    } reg_cmd_t;

    typedef struct packed {
        logic [7:0]  accumulator;
        logic [15:0] index_pointer_pair;
        logic [15:0] stack_pointer;
        logic [15:0] program_counter;
        logic [7:0]  condition_flags;
    } reg_view_t;
endpackage

// ### verilog/cpu_alu8.sv
module cpu_alu8
    import cpu_regs_pkg::*;
(
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] b_i,
    input  wire logic       carry_i,
    input  wire logic       sub_i,
    output logic      [7:0] sum_o,
    output logic            carry_o,
    output logic            half_o,
    output logic            ovf_o
);
    logic [7:0] b_eff;
    logic [8:0] full;
    logic [4:0] low;
    logic       cin;

    always_comb begin
        b_eff   = sub_i ? ~b_i : b_i;
        cin     = sub_i ? ~carry_i : carry_i;
        full    = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, cin};
        low     = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
        sum_o   = full[7:0];
        carry_o = sub_i ? ~full[8] : full[8];
        half_o  = low[4];
        ovf_o   = (a_i[7] == b_eff[7]) && (full[7] != a_i[7]);
    end
endmodule

// ### sim/cpu_register_set_and_flags_assertions.sv
module cpu_register_set_and_flags_assertions
    import cpu_regs_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        reset_n_i,
    input wire reg_cmd_t    cmd_i,
    input wire logic        irq_pending_i,
    input wire reg_view_t   view_o,
    input wire logic [15:0] alu_operand_o,
    input wire logic [15:0] index_addr_o,
    input wire logic [15:0] stack_addr_o,
    input wire logic        irq_accept_o,
    input wire logic        signed_gt_o,
    input wire logic        signed_ge_o,
    input wire logic        signed_le_o,
    input wire logic        signed_lt_o
);
    logic [15:0] sp_added;
    logic [8:0]  add_sum;
    logic [7:0]  fl;

    assign fl      = view_o.condition_flags;
    assign sp_added = view_o.stack_pointer + {{8{cmd_i.data8[7]}}, cmd_i.data8};
    assign add_sum = {1'b0, view_o.accumulator} + {1'b0, cmd_i.data8};

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    // clear-mask while masked, then the guarded boundary
    sequence s_mask_clear_masked;
        cmd_i.op == op_clear_mask_instruction && fl[flag_i_pos];
    endsequence
    sequence s_no_accept;
        !irq_accept_o;
    endsequence

    a_reset_values: assert property ($rose(reset_n_i) |->
        view_o.stack_pointer == 16'h00ff && view_o.index_pointer_pair[15:8] == 8'h00)
        else $error("reset values wrong");
    a_fixed_ones: assert property (fl[6:5] == 2'b11)
        else $error("fixed flag bits not one");
    a_stack_add: assert property (cmd_i.op == op_add_immediate_to_stack |=>
        view_o.stack_pointer == $past(sp_added)) else $error("stack add wrong");
    a_stack_low_reset: assert property (cmd_i.op == op_stack_pointer_low_reset |=>
        $stable(view_o.stack_pointer[15:8]) && view_o.stack_pointer[7:0] == sp_low_reset)
        else $error("stack low reset wrong");
    a_pc_step: assert property (cmd_i.pc_op == pc_inc |=>
        view_o.program_counter == $past(view_o.program_counter) + 16'h0001)
        else $error("pc step wrong");
    a_add_result: assert property (cmd_i.op == op_add |=>
        {fl[flag_c_pos], view_o.accumulator} == $past(add_sum)) else $error("add wrong");
    a_load_flags: assert property (cmd_i.op == op_lda |=>
        fl[flag_n_pos] == $past(cmd_i.data8[7]) && fl[flag_z_pos] == (view_o.accumulator == 8'h00))
        else $error("load flags wrong");
    a_irq_cause: assert property (irq_accept_o |->
        irq_pending_i && cmd_i.boundary && !fl[flag_i_pos]) else $error("irq accepted wrongly");
    a_mask_clear_guard: assert property (s_mask_clear_masked |=> s_no_accept)
        else $error("irq right after mask clear");
    a_stack_mask: assert property (cmd_i.irq_stacked |=> fl[flag_i_pos])
        else $error("mask not set on stacking");
    a_signed_cond: assert property (signed_lt_o == (fl[flag_n_pos] ^ fl[flag_v_pos])
        && signed_le_o == (signed_lt_o | fl[flag_z_pos])) else $error("signed branch wrong");
    a_pointer_out: assert property (alu_operand_o == {8'h00, view_o.accumulator}
        && index_addr_o == view_o.index_pointer_pair && stack_addr_o == view_o.stack_pointer)
        else $error("pointer outputs wrong");
endmodule

bind cpu_register_set_and_flags cpu_register_set_and_flags_assertions
    cpu_register_set_and_flags_assertions_i (.core_clk_i, .reset_n_i, .cmd_i, .irq_pending_i,
    .view_o, .alu_operand_o, .index_addr_o, .stack_addr_o, .irq_accept_o, .signed_gt_o,
    .signed_ge_o, .signed_le_o, .signed_lt_o);

// ### sim/test_cpu_register_set_and_flags.sv
module test_cpu_register_set_and_flags import cpu_regs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk_i;
    logic        reset_n_i;
    logic        irq_pending_i;
    reg_cmd_t    cmd_i;
    reg_view_t   view_o;
    logic [15:0] alu_operand_o;
    logic [15:0] index_addr_o;
    logic [15:0] stack_addr_o;
    logic        irq_accept_o;
    logic        signed_gt_o;
    logic        signed_ge_o;
    logic        signed_le_o;
    logic        signed_lt_o;
    int          miscompares;
    int          n_checks;

    cpu_register_set_and_flags cpu_register_set_and_flags_i (.core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i), .cmd_i(cmd_i), .irq_pending_i(irq_pending_i), .view_o(view_o),
        .alu_operand_o(alu_operand_o), .index_addr_o(index_addr_o),
        .stack_addr_o(stack_addr_o), .irq_accept_o(irq_accept_o), .signed_gt_o(signed_gt_o),
        .signed_ge_o(signed_ge_o), .signed_le_o(signed_le_o), .signed_lt_o(signed_lt_o));

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic issue(input reg_op_t op, input logic [7:0] d8, input logic [15:0] d16);
        @(negedge core_clk_i);
        cmd_i.op = op;
        cmd_i.data8 = d8;
        cmd_i.data16 = d16;
        @(negedge core_clk_i);
        cmd_i.op = op_none;
    endtask

    task automatic pcop(input pc_op_t p, input logic [15:0] d);
        @(negedge core_clk_i);
        cmd_i.pc_op = p;
        cmd_i.pc_data = d;
        @(negedge core_clk_i);
        cmd_i.pc_op = pc_hold;
    endtask

    task automatic complete_run;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // mid-run reset keeps accumulator and index low byte
    task automatic test_reset;
        issue(op_lda, 8'h5a, 16'h0000);
        issue(op_ldhx, 8'h00, 16'h1234);
        @(negedge core_clk_i);
        reset_n_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        check({8'h00, view_o.accumulator}, 16'h005a, "acc after reset");
        check(view_o.index_pointer_pair, 16'h0034, "index after reset");
        check(view_o.stack_pointer, 16'h00ff, "sp after reset");
    endtask

    task automatic test_pc;
        pcop(pc_vec_hi, 16'h00c1);
        pcop(pc_vec_lo, 16'h0023);
        check(view_o.program_counter, 16'hc123, "reset vector");
        pcop(pc_inc, 16'h0000);
        check(view_o.program_counter, 16'hc124, "pc step");
        pcop(pc_load, 16'h8000);
        pcop(pc_rel, 16'hfffe);
        check(view_o.program_counter, 16'h7ffe, "pc change of flow");
    endtask

    task automatic test_add;
        logic [7:0] aa[5] = '{8'h08, 8'h7f, 8'hff, 8'h80, 8'h05};
        logic [7:0] bb[5] = '{8'h08, 8'h01, 8'h01, 8'h80, 8'h03};
        logic [8:0] s;
        logic       h;
        logic       v;
        logic [15:0] g;
        for (int i = 0; i < 5; i++) begin
            issue(op_lda, aa[i], 16'h0000);
            issue(op_add, bb[i], 16'h0000);
            s = {1'b0, aa[i]} + {1'b0, bb[i]};
            h = ({1'b0, aa[i][3:0]} + {1'b0, bb[i][3:0]}) > 5'h0f;
            v = (aa[i][7] == bb[i][7]) && (s[7] != aa[i][7]);
            check(alu_operand_o, {8'h00, s[7:0]}, "add result");
            check({11'h000, view_o.condition_flags[7], view_o.condition_flags[4],
                view_o.condition_flags[2:0]}, {11'h000, v, h, s[7], s[7:0] == 8'h00, s[8]},
                "add flags");
            g = {12'h000, ~(s[7] ^ v) & |s[7:0], ~(s[7] ^ v), (s[7] ^ v) | ~|s[7:0], s[7] ^ v};
            check({12'h000, signed_gt_o, signed_ge_o, signed_le_o, signed_lt_o}, g, "cond");
        end
        issue(op_lda, 8'h00, 16'h0000);
        issue(op_sub, 8'h01, 16'h0000);
        check({view_o.accumulator, view_o.condition_flags & 8'h05}, 16'hff05, "borrow");
    endtask

    task automatic test_decimal_adjust;
        issue(op_lda, 8'h09, 16'h0000);
        issue(op_add, 8'h08, 16'h0000);
        issue(op_decimal_adjust_instruction, 8'h00, 16'h0000);
        check({8'h00, view_o.accumulator}, 16'h0017, "bcd low fix");
        issue(op_lda, 8'h99, 16'h0000);
        issue(op_add, 8'h01, 16'h0000);
        issue(op_decimal_adjust_instruction, 8'h00, 16'h0000);
        check({view_o.accumulator, 7'h00, view_o.condition_flags[0]}, 16'h0001, "bcd carry");
    endtask

    task automatic test_index;
        reg_op_t    xo[7] = '{op_xinc, op_xdec, op_xcom, op_xneg, op_xlsl, op_xlsr, op_xclr};
        logic [7:0] xe[7] = '{8'h82, 8'h81, 8'h7e, 8'h82, 8'h04, 8'h02, 8'h00};
        issue(op_ldhx, 8'h00, 16'h1281);
        for (int i = 0; i < 7; i++) begin
            issue(xo[i], 8'h00, 16'h0000);
            check(index_addr_o, {8'h12, xe[i]}, "index low op");
        end
        check({15'h0000, view_o.condition_flags[1]}, 16'h0001, "index zero");
    endtask

    task automatic test_stack;
        reg_op_t     so[4] = '{op_add_immediate_to_stack, op_stack_pointer_low_reset,
                               op_add_immediate_to_stack, op_add_immediate_to_stack};
        logic [7:0]  sd[4] = '{8'h7f, 8'h00, 8'hfe, 8'h80};
        logic [15:0] se[4] = '{16'h017e, 16'h01ff, 16'h01fd, 16'h017d};
        for (int i = 0; i < 4; i++) begin
            issue(so[i], sd[i], 16'h0000);
            check(view_o.stack_pointer, se[i], "stack pointer");
            check(stack_addr_o, se[i], "stack address");
        end
    endtask

    task automatic test_loads;
        reg_op_t     lo[4] = '{op_lda, op_lda, op_ldhx, op_ldhx};
        logic [15:0] ld[4] = '{16'h0080, 16'h0000, 16'h0000, 16'h8000};
        logic [1:0]  le[4] = '{2'b10, 2'b01, 2'b01, 2'b10};
        for (int i = 0; i < 4; i++) begin
            issue(lo[i], ld[i][7:0], ld[i]);
            check({14'h0000, view_o.condition_flags[2:1]}, {14'h0000, le[i]}, "load nz");
        end
    endtask

    task automatic test_irq;
        @(negedge core_clk_i);
        cmd_i.op = op_clear_mask_instruction;
        irq_pending_i = 1'b1;
        @(negedge core_clk_i);
        cmd_i.op = op_none;
        cmd_i.boundary = 1'b1;
        #1 check({15'h0000, irq_accept_o}, 16'h0000, "irq after clear");
        @(negedge core_clk_i);
        #1 check({15'h0000, irq_accept_o}, 16'h0001, "irq unmasked");
        @(negedge core_clk_i);
        cmd_i.op = op_sei;
        cmd_i.boundary = 1'b0;
        @(negedge core_clk_i);
        cmd_i.op = op_none;
        cmd_i.boundary = 1'b1;
        #1 check({15'h0000, irq_accept_o}, 16'h0000, "irq masked");
        issue(op_lda, 8'h00, 16'h0000);
        issue(op_tap, 8'h00, 16'h0000);
        check({8'h00, view_o.condition_flags}, 16'h0060, "flag write");
        @(negedge core_clk_i);
        cmd_i.irq_stacked = 1'b1;
        cmd_i.boundary = 1'b0;
        @(negedge core_clk_i);
        cmd_i.irq_stacked = 1'b0;
        irq_pending_i = 1'b0;
        check({15'h0000, view_o.condition_flags[3]}, 16'h0001, "mask on stacking");
    endtask

    initial begin
        miscompares = 0;
        n_checks = 0;
        reset_n_i = 1'b0;
        irq_pending_i = 1'b0;
        cmd_i = '0;
        repeat (14) @(posedge core_clk_i);
        // give the unreset data registers a known value
        @(negedge core_clk_i);
        cmd_i.op = op_ldhx;
        @(negedge core_clk_i);
        cmd_i.op = op_lda;
        @(negedge core_clk_i);
        cmd_i.op = op_none;
        reset_n_i = 1'b1;
        check(view_o.stack_pointer, 16'h00ff, "sp reset");
        check({8'h00, view_o.condition_flags & 8'h68}, 16'h0068, "flags reset");
        test_reset();
        test_pc();
        test_add();
        test_decimal_adjust();
        test_index();
        test_stack();
        test_loads();
        test_irq();
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge core_clk_i);
        miscompares++;
        complete_run();
    end
endmodule
